// ===== src/dwp_write_port.sv
// Purpose: Write-only two-wire target driving two 256-tap wipers
// Assumes: Bus lines synchronous to sys_clk, sampled well above bus rate
// Notes:   Never answers reads with data; only acknowledges writes
`timescale 1ns/1ps
`default_nettype none
`include "dwp_defs.svh"
// Summary of operation
// RULE_01 - Command 0x11 stores next data byte in the first wiper.
// RULE_02 - Command 0x12 stores next data byte in the second wiper.
// RULE_03 - Command 0x13 stores the same data byte in both wipers.
// RULE_04 - Wiper position is one full eight-bit byte after the command.
// RULE_05 - Each wiper has 256 positions, one per data value.
// RULE_06 - Device never drives data back; reads get no data.
// RULE_07 - Master writes address, command, data, each acknowledged.
// RULE_08 - Master clocks the bus at 400kHz or 100kHz.
// RULE_09 - Wiper registers are volatile and follow the latest write.
// RULE_10 - Master sends seven-bit address with write bit zero.
// RULE_11 - Low three address bits come from straps; only match answers.
// RULE_12 - Unknown command codes leave both wipers unchanged.
module dwp_write_port (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// Two-wire bus
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Address straps
	input  wire logic       address_strap_high,
	input  wire logic       address_strap_mid,
	input  wire logic       address_strap_low,
	// Wiper taps
	output logic [7:0]      first_wiper_terminal,
	output logic [7:0]      second_wiper_terminal
);
	logic                   rst_s1;
	logic                   rst_n;
	logic                   scl_d;
	logic                   sda_d;
	logic [7:0]             shift;
	logic [3:0]             bit_cnt;
	logic [7:0]             cmd;
	logic                   wr_first;
	logic                   wr_second;
	logic [7:0]             wr_data;
	logic [2:0]             strap;
	dwp_pkg::dwp_state_t    state;
	dwp_pkg::dwp_state_t    after_ack;
	logic                   scl_rise;
	logic                   scl_fall;
	logic                   start_c;
	logic                   stop_c;
	logic [7:0]             byte_in;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_in;
			sda_d <= sda_in;
		end
	end

	// Straps caught after release so a floating pin in reset is harmless
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			strap <= 3'h0;
		else
			strap <= {address_strap_high, address_strap_mid,
				address_strap_low};
	end

	assign scl_rise = scl_in && !scl_d;
	assign scl_fall = !scl_in && scl_d;
	assign start_c  = scl_in && scl_d && sda_d && !sda_in;
	assign stop_c   = scl_in && scl_d && !sda_d && sda_in;
	assign byte_in  = {shift[6:0], sda_in};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= dwp_pkg::DWP_IDLE;
			after_ack <= dwp_pkg::DWP_IDLE;
			shift     <= 8'h00;
			bit_cnt   <= 4'h0;
			cmd       <= 8'h00;
			wr_first  <= 1'b0;
			wr_second <= 1'b0;
			wr_data   <= 8'h00;
		end else begin
			wr_first  <= 1'b0;
			wr_second <= 1'b0;
			if (start_c) begin
				state   <= dwp_pkg::DWP_ADDR;
				bit_cnt <= 4'h0;
			end else if (stop_c) begin
				state <= dwp_pkg::DWP_IDLE;
			end else begin
				unique case (state)
				dwp_pkg::DWP_IDLE, dwp_pkg::DWP_IGNORE: begin
				end
				dwp_pkg::DWP_ADDR, dwp_pkg::DWP_CMD,
				dwp_pkg::DWP_DATA: begin
					if (scl_rise) begin
						shift   <= byte_in;
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == 4'h7) begin
							bit_cnt <= 4'h0;
							if (state == dwp_pkg::DWP_ADDR) begin
								// Reads are not acknowledged: no data ever returns
								if (byte_in[7:1] == {`DWP_ADDR_UPPER, strap} // RULE_11
									&& byte_in[0] == 1'(`DWP_RW_BIT)) begin // RULE_06
									state     <= dwp_pkg::DWP_ACK;
									after_ack <= dwp_pkg::DWP_CMD;
								end else
									state <= dwp_pkg::DWP_IGNORE;
							end else if (state == dwp_pkg::DWP_CMD) begin
								cmd       <= byte_in;
								state     <= dwp_pkg::DWP_ACK;
								after_ack <= dwp_pkg::DWP_DATA;
							end else begin
								wr_data   <= byte_in; // RULE_04
								wr_first  <= (cmd == `DWP_CMD_FIRST) // RULE_01
									|| (cmd == `DWP_CMD_JOINT); // RULE_03
								wr_second <= (cmd == `DWP_CMD_SECOND) // RULE_02
									|| (cmd == `DWP_CMD_JOINT); // RULE_12
								state     <= dwp_pkg::DWP_ACK;
								after_ack <= dwp_pkg::DWP_CMD;
							end
						end
					end
				end
				dwp_pkg::DWP_ACK: begin
					if (scl_fall && !sda_oe)
						state <= dwp_pkg::DWP_ACK;
					else if (scl_fall && sda_oe)
						state <= after_ack;
				end
				endcase
			end
		end
	end

	// Pull SDA low through the ninth clock only; never drive data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			sda_oe <= 1'b0;
		else if (start_c || stop_c)
			sda_oe <= 1'b0;
		else if (state == dwp_pkg::DWP_ACK && scl_fall)
			sda_oe <= !sda_oe;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0; // RULE_06
	end

	dwp_wiper_bank #(
		.WIDTH      (8)
	) u_bank (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.wr_first   (wr_first),
		.wr_second  (wr_second),
		.wr_data    (wr_data),
		.first_pos  (first_wiper_terminal), // RULE_05
		.second_pos (second_wiper_terminal)
	);

	AST_JOINT_BOTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_first && wr_second |-> cmd == `DWP_CMD_JOINT) // RULE_03
		else $error("joint write without joint command");
	AST_FIRST_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_first |=> first_wiper_terminal == $past(wr_data)) // RULE_01
		else $error("first wiper did not take data");
	AST_SECOND_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_second |=> second_wiper_terminal == $past(wr_data)) // RULE_02
		else $error("second wiper did not take data");
	AST_UNKNOWN_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_first || wr_second) |-> (cmd == `DWP_CMD_FIRST
		|| cmd == `DWP_CMD_SECOND || cmd == `DWP_CMD_JOINT)) // RULE_12
		else $error("wiper written on unknown command");
	AST_NO_DRIVE_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sda_oe |-> !sda_out) // RULE_06
		else $error("sda driven high");
	AST_HOLD_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!wr_first |=> $stable(first_wiper_terminal)) // RULE_09
		else $error("first wiper moved without write");
	AST_ACK_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(sda_oe) |-> $past(state) == dwp_pkg::DWP_ACK) // RULE_11
		else $error("sda pulled outside acknowledge");
	AST_B_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!wr_second |=> $stable(second_wiper_terminal)) // RULE_09
		else $error("second wiper moved without write");
	// A refused address or a read must leave SDA to the pull-up
	AST_IGNORE_SILENT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state == dwp_pkg::DWP_IGNORE |-> !sda_oe) // RULE_11
		else $error("sda pulled while transfer is ignored");
	// Strobes only ever follow a complete data byte
	AST_STROBE_AFTER_DATA: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_first || wr_second) |-> $past(state) == dwp_pkg::DWP_DATA) // RULE_04
		else $error("wiper strobe outside data byte");
endmodule : dwp_write_port
`default_nettype wire

// ===== src/dwp_defs.svh
// Purpose: Constants of the dual wiper write port
// Assumes: Seven-bit target address, upper bits fixed
// Notes:   Command codes select which wiper takes the data byte
`ifndef DWP_DEFS_SVH
`define DWP_DEFS_SVH
`define DWP_CMD_FIRST      8'h11
`define DWP_CMD_SECOND     8'h12
`define DWP_CMD_JOINT      8'h13
`define DWP_ADDR_UPPER     4'h5
`define DWP_WIPER_RESET    8'h80
`define DWP_RW_BIT         0
`endif

// ===== src/dwp_pkg.sv
// Purpose: Types of the dual wiper write port
// Assumes: Nothing beyond the defs header
// Notes:   Holds the transfer state enumeration
package dwp_pkg;
	typedef enum logic [2:0] {
		DWP_IDLE,
		DWP_ADDR,
		DWP_CMD,
		DWP_DATA,
		DWP_ACK,
		DWP_IGNORE
	} dwp_state_t;
endpackage : dwp_pkg

// ===== src/dwp_wiper_bank.sv
// Purpose: Holds the two volatile wiper positions
// Assumes: Write strobes are one-cycle pulses
// Notes:   Wiper positions come out of registers
`timescale 1ns/1ps
`default_nettype none
`include "dwp_defs.svh"
module dwp_wiper_bank #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Write side
	input  wire logic             wr_first,
	input  wire logic             wr_second,
	input  wire logic [WIDTH-1:0] wr_data,
	// Positions
	output logic      [WIDTH-1:0] first_pos,
	output logic      [WIDTH-1:0] second_pos
);
	// Refused at elaboration: the command decode only serves byte-wide taps
	if (WIDTH != 8) begin : g_bad_width
		$error("dwp_wiper_bank: WIDTH must be 8");
	end

	// Volatile: reset returns to midscale, no stored copy
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			first_pos <= `DWP_WIPER_RESET;
		else if (wr_first)
			first_pos <= wr_data; // RULE_09
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			second_pos <= `DWP_WIPER_RESET;
		else if (wr_second)
			second_pos <= wr_data; // RULE_09
	end
endmodule : dwp_wiper_bank
`default_nettype wire

// ===== tb/dwp_bus_master.sv
// Purpose: Behavioural two-wire bus master for the wiper write port
// Assumes: SDA pulled up; the resolved level comes in as sda_line
// Notes:   Q is sys_clk cycles a quarter bit; 25 gives 400kHz
`timescale 1ns/1ps
`default_nettype none
module dwp_bus_master #(
	parameter int Q = 25
) (
	// Clock
	input  wire logic sys_clk,
	// Bus
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	// Data moves only while SCL is low, so no false START or STOP
	task automatic bit_x(input logic b, output logic s);
		sda_m = b;
		tick(Q);
		scl = 1'b1;
		tick(Q);
		s = sda_line;
		tick(Q);
		scl = 1'b0;
		tick(Q);
	endtask : bit_x
	task automatic byte_x(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(b[i], s);
		bit_x(1'b1, s);
		ack = ~s;
	endtask : byte_x
	task automatic wr(input logic [7:0] ab, input logic [7:0] c,
		input logic [7:0] d, output logic [2:0] k);
		sda_m = 1'b0;
		tick(Q);
		scl = 1'b0;
		tick(Q);
		byte_x(ab, k[2]);
		byte_x(c, k[1]);
		byte_x(d, k[0]);
		sda_m = 1'b0;
		tick(Q);
		scl = 1'b1;
		tick(Q);
		sda_m = 1'b1;
		tick(4 * Q);
	endtask : wr
endmodule : dwp_bus_master
`default_nettype wire

// ===== tb/dwp_write_port_tb.sv
// Purpose: Self-checking bench of the wiper write port
// Assumes: Straps fixed at 3'h5, so the target is 7'h2D
// Notes:   Rows hold address, command, data, wipers, acks
`timescale 1ns/1ps
`default_nettype none
`include "dwp_defs.svh"
`define TB_CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module dwp_write_port_tb;
	typedef struct packed {
		logic [6:0] a;
		logic [7:0] c;
		logic [7:0] d;
		logic [7:0] ea;
		logic [7:0] eb;
		logic [2:0] k;
	} dwp_row_t;
	logic       sys_clk = 1'b0;
	logic       reset_n = 1'b0;
	logic [2:0] strap   = 3'h5;
	logic       scl;
	logic       sda_m;
	logic       sda_out;
	logic       sda_oe;
	logic [7:0] wa;
	logic [7:0] wb;
	logic [2:0] acks;
	int         n_fail  = 0;
	int         checks  = 0;
	// Open drain with pull-up
	wire logic  sda = sda_m & ~(sda_oe & ~sda_out);
	dwp_row_t   rows [6] = '{
		'{7'h2D, `DWP_CMD_FIRST, 8'h00, 8'h00, 8'h80, 3'h7},
		'{7'h2D, `DWP_CMD_SECOND, 8'hFF, 8'h00, 8'hFF, 3'h7},
		'{7'h2D, `DWP_CMD_JOINT, 8'h5A, 8'h5A, 8'h5A, 3'h7},
		'{7'h2D, 8'h14, 8'h33, 8'h5A, 8'h5A, 3'h7},
		'{7'h2A, `DWP_CMD_FIRST, 8'h77, 8'h5A, 8'h5A, 3'h0},
		'{7'h2D, `DWP_CMD_FIRST, 8'hA5, 8'hA5, 8'h5A, 3'h7}
	};
	dwp_bus_master u_mst (
		.sys_clk (sys_clk),
		.sda_line(sda),
		.scl     (scl),
		.sda_m   (sda_m)
	);
	dwp_write_port u_dut (
		.sys_clk              (sys_clk),
		.reset_n              (reset_n),
		.scl_in               (scl),
		.sda_in               (sda),
		.sda_out              (sda_out),
		.sda_oe               (sda_oe),
		.address_strap_high   (strap[2]),
		.address_strap_mid    (strap[1]),
		.address_strap_low    (strap[0]),
		.first_wiper_terminal (wa),
		.second_wiper_terminal(wb)
	);
	initial forever #12.5 sys_clk = ~sys_clk;
	task automatic summarize;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	// A hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge sys_clk);
		n_fail++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		repeat (8) @(posedge sys_clk);
		#1;
		`TB_CHK("reset a", `DWP_WIPER_RESET, wa)
		`TB_CHK("reset b", `DWP_WIPER_RESET, wb)
		foreach (rows[i]) begin
			u_mst.wr({rows[i].a, 1'b0}, rows[i].c, rows[i].d, acks);
			`TB_CHK("acks", rows[i].k, acks)
			`TB_CHK("wiper a", rows[i].ea, wa)
			`TB_CHK("wiper b", rows[i].eb, wb)
		end
		u_mst.wr({7'h2D, 1'b1}, `DWP_CMD_FIRST, 8'h01, acks);
		`TB_CHK("read acks", 3'h0, acks)
		`TB_CHK("read a", 8'hA5, wa)
		`TB_CHK("sda out", 1'b0, sda_out)
		@(posedge sys_clk);
		#1 reset_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		`TB_CHK("rst b", `DWP_WIPER_RESET, wb)
		`TB_CHK("rst oe", 1'b0, sda_oe)
		@(posedge sys_clk);
		#1 reset_n = 1'b1;
		repeat (8) @(posedge sys_clk);
		#1;
		u_mst.wr({7'h2D, 1'b0}, `DWP_CMD_JOINT, 8'hFF, acks);
		`TB_CHK("joint a", 8'hFF, wa)
		`TB_CHK("joint b", 8'hFF, wb)
		summarize();
	end
endmodule : dwp_write_port_tb
`default_nettype wire
